// [verilog/line_unit_cfg.svh]
// Register offsets, field positions, reset values and limits of the
// line unit host and interrupt register bank.
// Assumes inclusion by bare name from the design files that need it.
`ifndef LINE_UNIT_CFG_SVH
`define LINE_UNIT_CFG_SVH

// ==========================================================
// Register offsets (six-bit host address)
`define LU_OFS_POWER        6'h00
`define LU_OFS_IRQ_EN       6'h01
`define LU_OFS_IRQ_FLAGS    6'h02
`define LU_OFS_GLOBAL_EN    6'h20
`define LU_OFS_GLOBAL_FLAG  6'h21
`define LU_OFS_COUNT_HIGH   6'h30
`define LU_OFS_COUNT_LOW    6'h31
`define LU_OFS_HOLDING      6'h38
`define LU_OFS_PART_NUMBER  6'h3e
`define LU_OFS_PART_REV     6'h3f

// ==========================================================
// Field positions
`define LU_BIT_TX_ON        0
`define LU_BIT_RX_ON        4
`define LU_BIT_DRIVER_FAIL  0
`define LU_BIT_SIGNAL_LOSS  1
`define LU_BIT_LOCK_LOSS    2
`define LU_BIT_JITTER_LIMIT 3
`define LU_BIT_PATTERN_ERR  4
`define LU_BIT_COUNT_FULL   5
`define LU_BIT_GLOBAL       0

// ==========================================================
// Reset values and limits
`define LU_RST_POWER        8'h00
`define LU_RST_IRQ_EN       6'h00
`define LU_RST_IRQ_FLAGS    6'h00
`define LU_RST_GLOBAL_EN    1'b0
`define LU_RST_COUNT        16'h0000
`define LU_COUNT_MAX        16'hffff
`define LU_IRQ_MASK_ALL     6'h3f

`endif

// [verilog/line_unit_pkg.sv]
// Types shared by the line unit register bank and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package line_unit_pkg;

  // ==========================================================
  // Host register access, one request per cycle
  typedef struct packed {
    logic       wr;     // Write strobe, one cycle
    logic       rd;     // Read strobe, one cycle
    logic [5:0] addr;   // Register offset
    logic [7:0] wdata;  // Write data
  } reg_req_t;

  // ==========================================================
  // Alarm status levels from the line logic
  typedef struct packed {
    logic jitter_buf_limit;
    logic rx_lock_loss;
    logic rx_signal_loss;
    logic driver_fail;
  } alarm_t;

endpackage

`default_nettype wire

// [verilog/alarm_change.sv]
// Change detector for the alarm status levels, one lane per alarm.
// Assumes the levels come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module alarm_change (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire line_unit_pkg::alarm_t status,
  output logic [3:0]                 change
);
  import line_unit_pkg::*;

  logic [3:0] level;
  logic [3:0] prev_reg;

  assign level = status;

  // ==========================================================
  // Per-lane previous level and change term
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_lane
      always_ff @(posedge clk) begin
        if (rst) begin
          prev_reg[i] <= 1'b0;
        end else begin
          prev_reg[i] <= level[i];
        end
      end
      assign change[i] = level[i] ^ prev_reg[i];
    end
  endgenerate
endmodule

`default_nettype wire

// [verilog/error_counter.sv]
// Sixteen-bit saturating counter of test-pattern bit errors.
// Assumes one error pulse per cycle at most, on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "line_unit_cfg.svh"

module error_counter (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        error_pulse,
  output logic [15:0]      count_reg,
  output logic             full_pulse
);
  logic at_max;

  assign at_max = (count_reg == `LU_COUNT_MAX);

  // ==========================================================
  // Count up, stop at the top, flag the arrival there
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg  <= `LU_RST_COUNT;
      full_pulse <= 1'b0;
    end else begin
      full_pulse <= 1'b0;
      if (error_pulse && !at_max) begin
        count_reg <= count_reg + 16'h0001;
        if (count_reg == (`LU_COUNT_MAX - 16'h0001)) begin
          full_pulse <= 1'b1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// [verilog/line_unit_host_irq_registers.sv]
// Host control and interrupt register bank of a single-channel line unit.
// Assumes the serial host port decodes into one-cycle read and write
// strobes on CLK, and that alarm levels and the error pulse come from
// logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "line_unit_cfg.svh"

module line_unit_host_irq_registers #(
  parameter logic [7:0] PART_NUMBER   = 8'h5a,  // Arbitrary value
  parameter logic [7:0] PART_REVISION = 8'h01   // Arbitrary value
) (
  input  wire logic                    CLK,
  input  wire logic                    SYS_RST,
  input  wire line_unit_pkg::reg_req_t REG_REQ,
  output logic [7:0]                   RDATA,
  input  wire line_unit_pkg::alarm_t   ALARM_IN,
  input  wire logic                    JA_ENABLED,
  input  wire logic                    PATTERN_ERROR,
  output logic                         RX_ON,
  output logic                         TX_ON,
  output logic                         TX_OE_N,
  output logic                         INT_N
);
  import line_unit_pkg::*;

  // ==========================================================
  // Declarations
  logic [7:0]  power_reg;
  logic [5:0]  irq_en_reg;
  logic [5:0]  flags_reg;
  logic [5:0]  flags_next;
  logic        global_en_reg;
  logic        global_flag_reg;
  logic [7:0]  holding_reg;
  logic [7:0]  rdata_reg;
  logic        int_n_reg;
  logic [3:0]  alarm_chg;
  logic [15:0] count;
  logic        count_full;
  logic [5:0]  flag_set;
  logic        flag_clr;
  logic [5:0]  en_eff;
  logic        irq_next;
  logic [7:0]  read_mux;
  logic        wr_power;
  logic        wr_irq_en;
  logic        wr_global;

  assign wr_power  = REG_REQ.wr && (REG_REQ.addr == `LU_OFS_POWER);
  assign wr_irq_en = REG_REQ.wr && (REG_REQ.addr == `LU_OFS_IRQ_EN);
  assign wr_global = REG_REQ.wr && (REG_REQ.addr == `LU_OFS_GLOBAL_EN);

  // ==========================================================
  // Helpers
  alarm_change u_alarm_change (
    .clk    (CLK),
    .rst    (SYS_RST),
    .status (ALARM_IN),
    .change (alarm_chg)
  );

  error_counter u_error_counter (
    .clk         (CLK),
    .rst         (SYS_RST),
    .error_pulse (PATTERN_ERROR),
    .count_reg   (count),
    .full_pulse  (count_full)
  );

  // ==========================================================
  // Power control register
  // receiver power bit
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      power_reg <= `LU_RST_POWER;
    end else if (wr_power) begin
      power_reg <= 8'h00;
      power_reg[`LU_BIT_RX_ON] <= REG_REQ.wdata[`LU_BIT_RX_ON];
      power_reg[`LU_BIT_TX_ON] <= REG_REQ.wdata[`LU_BIT_TX_ON];
    end
  end

  // Power outputs, line output enable low while driving
  // tri-state when off
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RX_ON   <= 1'b0;
      TX_ON   <= 1'b0;
      TX_OE_N <= 1'b1;
    end else begin
      RX_ON   <= wr_power ? REG_REQ.wdata[`LU_BIT_RX_ON] : power_reg[`LU_BIT_RX_ON];
      TX_ON   <= wr_power ? REG_REQ.wdata[`LU_BIT_TX_ON] : power_reg[`LU_BIT_TX_ON];
      TX_OE_N <= wr_power ? !REG_REQ.wdata[`LU_BIT_TX_ON] : !power_reg[`LU_BIT_TX_ON];
    end
  end

  // ==========================================================
  // Interrupt enable registers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      irq_en_reg <= `LU_RST_IRQ_EN;
    end else if (wr_irq_en) begin
      irq_en_reg <= REG_REQ.wdata[5:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      global_en_reg <= `LU_RST_GLOBAL_EN;
    end else if (wr_global) begin
      global_en_reg <= REG_REQ.wdata[`LU_BIT_GLOBAL];
    end
  end

  // ==========================================================
  // Sticky interrupt flags, set wins over clear-on-read
  // driver change sets
  assign flag_set = {count_full, PATTERN_ERROR, alarm_chg};
  assign flag_clr = REG_REQ.rd && (REG_REQ.addr == `LU_OFS_IRQ_FLAGS);

  always_comb begin
    flags_next = flags_reg;
    if (flag_clr) begin
      flags_next = `LU_RST_IRQ_FLAGS;
    end
    flags_next = flags_next | flag_set;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      flags_reg <= `LU_RST_IRQ_FLAGS;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ==========================================================
  // Interrupt combine and output
  // driver-fail enable
  always_comb begin
    en_eff = irq_en_reg & `LU_IRQ_MASK_ALL;
    en_eff[`LU_BIT_JITTER_LIMIT] = irq_en_reg[`LU_BIT_JITTER_LIMIT] && JA_ENABLED;
  end

  assign irq_next = (|(flags_reg & en_eff)) && global_en_reg;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      int_n_reg       <= 1'b1;
      global_flag_reg <= 1'b0;
    end else begin
      int_n_reg       <= !irq_next;
      global_flag_reg <= irq_next;
    end
  end

  assign INT_N = int_n_reg;

  // ==========================================================
  // Error count holding byte, caught when the high byte is read
  // byte-split count
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      holding_reg <= 8'h00;
    end else if (REG_REQ.rd && (REG_REQ.addr == `LU_OFS_COUNT_HIGH)) begin
      holding_reg <= count[7:0];
    end
  end

  // ==========================================================
  // Read data mux, unmapped offsets read zero
  // identity registers
  always_comb begin
    read_mux = 8'h00;
    case (REG_REQ.addr)
      `LU_OFS_POWER:       read_mux = power_reg;
      `LU_OFS_IRQ_EN:      read_mux = {2'b00, irq_en_reg};
      `LU_OFS_IRQ_FLAGS:   read_mux = {2'b00, flags_reg};
      `LU_OFS_GLOBAL_EN:   read_mux = {7'h00, global_en_reg};
      `LU_OFS_GLOBAL_FLAG: read_mux = {7'h00, global_flag_reg};
      `LU_OFS_COUNT_HIGH:  read_mux = count[15:8];
      `LU_OFS_COUNT_LOW:   read_mux = count[7:0];
      `LU_OFS_HOLDING:     read_mux = holding_reg;
      `LU_OFS_PART_NUMBER: read_mux = PART_NUMBER;
      `LU_OFS_PART_REV:    read_mux = PART_REVISION;
      default:             read_mux = 8'h00;
    endcase
  end

  // Read data register holds until the next read
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_reg <= 8'h00;
    end else if (REG_REQ.rd) begin
      rdata_reg <= read_mux;
    end
  end

  assign RDATA = rdata_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  a_rx_power_write: assert property (
    wr_power |=> (RX_ON == $past(REG_REQ.wdata[`LU_BIT_RX_ON]))
              && (power_reg[`LU_BIT_RX_ON] == RX_ON))
    else $error("receiver power does not follow write");

  a_tx_tristate_off: assert property (
    (wr_power && !REG_REQ.wdata[`LU_BIT_TX_ON]) |=> (TX_OE_N && !TX_ON))
    else $error("line output not released with transmitter off");

  a_driver_irq_gate: assert property (
    (flags_reg == 6'h01 && irq_en_reg[`LU_BIT_DRIVER_FAIL] && global_en_reg)
      |=> !INT_N)
    else $error("enabled driver flag gives no interrupt");

  a_sigloss_irq_block: assert property (
    (flags_reg == 6'h02 && !irq_en_reg[`LU_BIT_SIGNAL_LOSS]) |=> INT_N)
    else $error("disabled signal-loss flag gives interrupt");

  a_lockloss_irq_gate: assert property (
    (flags_reg == 6'h04 && irq_en_reg[`LU_BIT_LOCK_LOSS] && global_en_reg)
      |=> !INT_N)
    else $error("enabled lock-loss flag gives no interrupt");

  a_jitter_irq_gate: assert property (
    (flags_reg == 6'h08 && !JA_ENABLED) |=> INT_N)
    else $error("jitter flag interrupts with attenuator off");

  a_pattern_irq_gate: assert property (
    (flags_reg == 6'h10 && irq_en_reg[`LU_BIT_PATTERN_ERR] && global_en_reg)
      |=> !INT_N)
    else $error("enabled pattern flag gives no interrupt");

  a_full_irq_gate: assert property (
    (flags_reg[`LU_BIT_COUNT_FULL] && irq_en_reg[`LU_BIT_COUNT_FULL] && global_en_reg)
      |=> !INT_N)
    else $error("enabled saturation flag gives no interrupt");

  a_driver_flag_set: assert property (
    $changed(ALARM_IN.driver_fail) |=> flags_reg[`LU_BIT_DRIVER_FAIL])
    else $error("driver change missed");

  a_sigloss_flag_set: assert property (
    $changed(ALARM_IN.rx_signal_loss) |=> flags_reg[`LU_BIT_SIGNAL_LOSS])
    else $error("signal-loss change missed");

  a_lockloss_flag_set: assert property (
    $changed(ALARM_IN.rx_lock_loss) |=> flags_reg[`LU_BIT_LOCK_LOSS])
    else $error("lock-loss change missed");

  a_jitter_flag_set: assert property (
    $changed(ALARM_IN.jitter_buf_limit) |=> flags_reg[`LU_BIT_JITTER_LIMIT])
    else $error("jitter-limit change missed");

  a_flags_read_clear: assert property (
    (flag_clr && flag_set == 6'h00) |=> (flags_reg == 6'h00))
    else $error("flags not cleared by read");

  a_count_saturate: assert property (
    (count == `LU_COUNT_MAX) |=> (count == `LU_COUNT_MAX))
    else $error("error counter wrapped");

  a_part_read: assert property (
    (REG_REQ.rd && REG_REQ.addr == `LU_OFS_PART_NUMBER) |=> (RDATA == PART_NUMBER))
    else $error("part number read wrong");

  a_int_active_low: assert property (
    INT_N == !global_flag_reg)
    else $error("interrupt pin polarity wrong");

  a_irq_quiet: assert property (
    ((flags_reg & en_eff) == 6'h00 || !global_en_reg) |=> (INT_N && !global_flag_reg))
    else $error("interrupt without enabled flag");

  a_count_increment: assert property (
    (PATTERN_ERROR && count != `LU_COUNT_MAX) |=> (count == $past(count) + 16'h0001))
    else $error("error counter did not advance");

  a_irq_raise: assert property (
    ((|(flags_reg & en_eff)) && global_en_reg) |=> (!INT_N && global_flag_reg))
    else $error("enabled flag with global enable gives no interrupt");

  a_pattern_flag_set: assert property (
    PATTERN_ERROR |=> flags_reg[`LU_BIT_PATTERN_ERR])
    else $error("pattern error flag missed");

  a_full_flag_set: assert property (
    (PATTERN_ERROR && count == (`LU_COUNT_MAX - 16'h0001)) |-> ##2 flags_reg[`LU_BIT_COUNT_FULL])
    else $error("saturation flag missed");

endmodule

`default_nettype wire

// [sim/host_model.sv]
// Host processor model issuing one-cycle register strobes to the bank.
// Assumes the bank takes a request on the rising CLK edge that sees it.
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic                   CLK,
  output var  line_unit_pkg::reg_req_t REG_REQ,
  input  wire logic [7:0]             RDATA
);
  import line_unit_pkg::*;

  // ==========================================================
  // Bus idle at time zero
  initial REG_REQ = '0;

  // Write strobe held to the taking edge, then released with scrambled fields
  task automatic write_reg(input logic [5:0] addr, input logic [7:0] data);
    @(posedge CLK);
    REG_REQ <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge CLK);
    REG_REQ <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
    #1;
  endtask

  // Read strobe held to the taking edge; data settles after that edge
  task automatic read_reg(input logic [5:0] addr, output logic [7:0] data);
    @(posedge CLK);
    REG_REQ <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge CLK);
    REG_REQ <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: 8'hff};
    #1;
    data = RDATA;
  endtask
endmodule

`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the line unit host and interrupt register bank.
// Assumes the host model drives the register port and the bench the alarms.
`timescale 1ns/1ps
`default_nettype none
`include "line_unit_cfg.svh"

module tb_top;
  import line_unit_pkg::*;

  localparam logic [7:0] PART_NUM = 8'h3c;  // Arbitrary value
  localparam logic [7:0] PART_REV = 8'h07;  // Arbitrary value

  logic       clk;
  logic       sys_rst;
  reg_req_t   reg_req;
  logic [7:0] rdata;
  alarm_t     alarm;
  logic       ja_en;
  logic       pat_err;
  logic       rx_on;
  logic       tx_on;
  logic       tx_oe_n;
  logic       int_n;
  int         err_total;
  int         n_compared;
  logic [7:0] d;
  logic [7:0] m;
  int         n;

  // ==========================================================
  // Design and host model
  line_unit_host_irq_registers #(
    .PART_NUMBER   (PART_NUM),
    .PART_REVISION (PART_REV)
  ) u_dut (
    .CLK           (clk),
    .SYS_RST       (sys_rst),
    .REG_REQ       (reg_req),
    .RDATA         (rdata),
    .ALARM_IN      (alarm),
    .JA_ENABLED    (ja_en),
    .PATTERN_ERROR (pat_err),
    .RX_ON         (rx_on),
    .TX_ON         (tx_on),
    .TX_OE_N       (tx_oe_n),
    .INT_N         (int_n)
  );

  host_model u_host (
    .CLK     (clk),
    .REG_REQ (reg_req),
    .RDATA   (rdata)
  );

  // Clock at 25 ns
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // Expectations and comparisons
  function automatic logic [7:0] power_read(input logic [7:0] w);
    return w & 8'h11;
  endfunction

  function automatic logic [15:0] sat_count(input int total);
    return (total > 65535) ? 16'hffff : total[15:0];
  endfunction

  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic rd_check(input logic [5:0] a, input logic [7:0] exp, input string name);
    logic [7:0] v;
    u_host.read_reg(a, v);
    check_byte(name, exp, v);
  endtask

  // Flip alarm levels at one edge
  task automatic toggle(input logic [3:0] mask);
    @(posedge clk);
    alarm <= alarm_t'(alarm ^ mask);
  endtask

  // Error pulses, back to back or randomly spaced
  task automatic pulse_errors(input int cnt, input bit spaced);
    repeat (cnt) begin
      @(posedge clk);
      pat_err <= 1'b1;
      if (spaced && $urandom_range(1) == 1) begin
        @(posedge clk);
        pat_err <= 1'b0;
      end
    end
    @(posedge clk);
    pat_err <= 1'b0;
    #1;
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    $display("ERROR watchdog expected finish seen timeout");
    complete_run();
  end

  // ==========================================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    alarm = '0;
    ja_en = 1'b1;
    pat_err = 1'b0;
    err_total = 0;
    n_compared = 0;
    void'($urandom(32'h0b83010f));
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    // Reset levels and register values, unmapped reads
    check_bit("tx_oe_n", 1'b1, tx_oe_n);
    check_bit("int_n", 1'b1, int_n);
    rd_check(`LU_OFS_POWER, 8'h00, "power");
    rd_check(`LU_OFS_IRQ_EN, 8'h00, "irq_en");
    rd_check(`LU_OFS_IRQ_FLAGS, 8'h00, "flags");
    rd_check(`LU_OFS_GLOBAL_FLAG, 8'h00, "global");
    rd_check(`LU_OFS_PART_NUMBER, PART_NUM, "part");
    rd_check(`LU_OFS_PART_REV, PART_REV, "rev");
    rd_check(6'h10, 8'h00, "unmapped");
    // Power control, corner values then random ones
    for (int k = 0; k < 6; k++) begin
      d = (k < 4) ? {3'h7, k[1], 3'h7, k[0]} : 8'($urandom);
      u_host.write_reg(`LU_OFS_POWER, d);
      check_bit("rx_on", d[4], rx_on);
      check_bit("tx_on", d[0], tx_on);
      check_bit("tx_oe_n", ~d[0], tx_oe_n);
      rd_check(`LU_OFS_POWER, power_read(d), "power");
    end
    // Writes to read-only places are ignored
    u_host.write_reg(`LU_OFS_PART_NUMBER, 8'h00);
    u_host.write_reg(`LU_OFS_GLOBAL_FLAG, 8'hff);
    rd_check(`LU_OFS_PART_NUMBER, PART_NUM, "part ro");
    rd_check(`LU_OFS_GLOBAL_FLAG, 8'h00, "global ro");
    // Enabled flag without global enable keeps the pin quiet
    u_host.write_reg(`LU_OFS_IRQ_EN, 8'h01);
    toggle(4'h1);
    repeat (3) @(posedge clk);
    #1;
    check_bit("int_n no global", 1'b1, int_n);
    rd_check(`LU_OFS_IRQ_FLAGS, 8'h01, "flags no global");
    // Each alarm: enabled change interrupts, disabled change only flags
    u_host.write_reg(`LU_OFS_GLOBAL_EN, 8'h01);
    rd_check(`LU_OFS_GLOBAL_EN, 8'h01, "global en");
    for (int i = 0; i < 4; i++) begin
      m = 8'h01 << i;
      u_host.write_reg(`LU_OFS_IRQ_EN, m);
      toggle(m[3:0]);
      @(posedge clk);
      #1;
      check_bit("int_n early", 1'b1, int_n);
      @(posedge clk);
      #1;
      check_bit("int_n", 1'b0, int_n);
      rd_check(`LU_OFS_GLOBAL_FLAG, 8'h01, "global");
      rd_check(`LU_OFS_IRQ_FLAGS, m, "flags");
      rd_check(`LU_OFS_IRQ_FLAGS, 8'h00, "flags clr");
      check_bit("int_n off", 1'b1, int_n);
      u_host.write_reg(`LU_OFS_IRQ_EN, 8'h00);
      toggle(m[3:0]);
      repeat (3) @(posedge clk);
      #1;
      check_bit("int_n masked", 1'b1, int_n);
      rd_check(`LU_OFS_IRQ_FLAGS, m, "flags fall");
    end
    // Jitter enable has no effect while the attenuator is off
    @(posedge clk);
    ja_en <= 1'b0;
    u_host.write_reg(`LU_OFS_IRQ_EN, 8'h08);
    toggle(4'h8);
    repeat (3) @(posedge clk);
    #1;
    check_bit("int_n ja off", 1'b1, int_n);
    rd_check(`LU_OFS_IRQ_FLAGS, 8'h08, "flags ja");
    // Pattern errors counted, flagged and held coherently
    n = 1 + $urandom_range(299);
    u_host.write_reg(`LU_OFS_IRQ_EN, 8'h10);
    pulse_errors(n, 1'b1);
    rd_check(`LU_OFS_COUNT_HIGH, 8'(sat_count(n) >> 8), "count hi");
    rd_check(`LU_OFS_HOLDING, 8'(sat_count(n)), "holding");
    rd_check(`LU_OFS_COUNT_LOW, 8'(sat_count(n)), "count lo");
    check_bit("int_n pattern", 1'b0, int_n);
    rd_check(`LU_OFS_IRQ_FLAGS, 8'h10, "flags pat");
    // Saturation at the top without wrapping
    u_host.write_reg(`LU_OFS_IRQ_EN, 8'h20);
    pulse_errors(65535 - n + 3, 1'b0);
    check_bit("int_n full", 1'b0, int_n);
    rd_check(`LU_OFS_IRQ_FLAGS, 8'h30, "flags sat");
    rd_check(`LU_OFS_COUNT_HIGH, 8'hff, "sat hi");
    rd_check(`LU_OFS_HOLDING, 8'hff, "sat hold");
    pulse_errors(2, 1'b0);
    rd_check(`LU_OFS_IRQ_FLAGS, 8'h10, "flags once");
    rd_check(`LU_OFS_COUNT_LOW, 8'hff, "sat lo");
    check_bit("int_n idle", 1'b1, int_n);
    complete_run();
  end
endmodule

`default_nettype wire
